//--- dv/remote_serial_model.sv
// far-end transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // command and line
  input wire logic hold_low,
  output logic line
);
  // idle is the pull-up level; a held low line is how the far end sends a break
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line <= 1'h1;
    end else begin
      line <= !hold_low;
    end
  end
endmodule : remote_serial_model
`default_nettype wire

//--- dv/test_uart_status_flag_logic.sv
// self-checking bench of the serial status flag block
`timescale 1ns/1ps
`default_nettype none
module test_uart_status_flag_logic;
  typedef struct packed {logic [2:0] act; logic [31:0] a; logic [31:0] d; logic [15:0] m; logic [15:0] e;} row_t;
  localparam logic [31:0] ST = uart_status_pkg::ADDR_STATUS;
  localparam logic [31:0] CF = uart_status_pkg::ADDR_CFG;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h1;
  logic arvalid = 1'h0;
  logic rready = 1'h1;
  logic [31:0] awaddr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] araddr = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_char_valid, line, vb, tb;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  logic [8:0] tx_char;
  logic [15:0] flag_events;
  uart_status_pkg::cfg_t cfg;
  uart_status_pkg::rx_event_t rx_event = '0;
  logic rx_busy = 1'h0;
  logic tx_busy = 1'h0;
  logic tx_take = 1'h0;
  logic mid_sample = 1'h0;
  logic sample_tick = 1'h0;
  logic loop_cts = 1'h0;
  logic bit_tick = 1'h0;
  logic cts_pin = 1'h0;
  logic hold_low = 1'h0;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  // act: 0 register write, 1 received char (d[9] stop bad, d[10] parity bad), 2 cts pin, 3 rx busy, 4 tx busy
  row_t rows [14] = '{
    '{3'h2, 32'h0, 32'h1, 16'h0030, 16'h0030}, '{3'h0, ST, 32'h20, 16'h0030, 16'h0010},
    '{3'h1, 32'h0, 32'h255, 16'h2001, 16'h2001}, '{3'h1, 32'h0, 32'h400, 16'h4101, 16'h0101},
    '{3'h0, CF, 32'h08, 16'h4000, 16'h0000}, '{3'h1, 32'h0, 32'h400, 16'h4000, 16'h4000},
    '{3'h0, ST, 32'h0F, 16'h000F, 16'h000F}, '{3'h0, ST, 32'hF920, 16'hF920, 16'h0000},
    '{3'h3, 32'h0, 32'h1, 16'h0002, 16'h0000}, '{3'h3, 32'h0, 32'h0, 16'h0002, 16'h0002},
    '{3'h4, 32'h0, 32'h1, 16'h0048, 16'h0000}, '{3'h0, CF, 32'h0C, 16'h0048, 16'h0000},
    '{3'h4, 32'h0, 32'h0, 16'h0048, 16'h0048}, '{3'h2, 32'h0, 32'h0, 16'h0030, 16'h0020}};

  uart_status_flag_logic uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .serial_input_pin(line),
    .cts_pin(cts_pin), .rx_event(rx_event), .rx_busy(rx_busy), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .mid_sample(mid_sample), .loop_cts(loop_cts), .rx_voted_bit(vb), .rx_voted_valid(), .tx_busy(tx_busy),
    .tx_take(tx_take), .tx_char(tx_char), .tx_char_valid(tx_char_valid), .cfg(cfg), .flag_events(flag_events));
  remote_serial_model far (.aclk(aclk), .aresetn(aresetn), .hold_low(hold_low), .line(line));

  // clock and hang guard
  always #10 aclk = !aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  // each channel is released at the edge that takes it; bready and rready stay high throughout
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      tb = bvalid;
    end
  endtask : wr

  // read data and response are taken at the edge that sees rvalid high
  task automatic rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    tb = 1'h0;
    while (!tb) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        tb = 1'h1;
        got = rdata;
        resp = rresp;
      end
    end
  endtask : rd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one-cycle strobe: 0 mid sample, 1 bit tick, 2 shifter take, 3 sample tick
  task automatic pulse(input int k);
    if (k == 0) mid_sample <= 1'h1;
    else if (k == 1) bit_tick <= 1'h1;
    else if (k == 2) tx_take <= 1'h1;
    else sample_tick <= 1'h1;
    @(posedge aclk);
    mid_sample <= 1'h0;
    bit_tick <= 1'h0;
    tx_take <= 1'h0;
    sample_tick <= 1'h0;
    @(posedge aclk);
  endtask : pulse

  task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (3) @(posedge aclk);
    rd(ST);
    chk(got[15:0], 32'h000E);
    $display("test reset done");
    // table of ordinary cases: stimulus, settle, then a masked status read
    foreach (rows[i]) begin
      case (rows[i].act)
        3'h0: wr(rows[i].a, rows[i].d);
        3'h1: begin
          rx_event <= {1'h1, rows[i].d[8:0], rows[i].d[9], rows[i].d[10]};
          @(posedge aclk);
          rx_event <= '0;
        end
        3'h2: cts_pin <= rows[i].d[0];
        3'h3: rx_busy <= rows[i].d[0];
        default: tx_busy <= rows[i].d[0];
      endcase
      repeat (5) @(posedge aclk);
      rd(ST);
      chk(got[15:0] & rows[i].m, rows[i].e);
      $display("test %0d done", i);
    end
    // the first character survives both overruns, and reading it empties the buffer
    rd(32'h4006_4014);
    chk(got[8:0], 32'h055);
    rd(ST);
    chk(got[0], 32'h0);
    // a write while halted is held back, then offered once the halt is lifted
    wr(32'h4006_401C, 32'h41);
    rd(ST);
    chk(got[2], 32'h0);
    chk({tx_char_valid, tx_char}, 32'h041);
    wr(CF, 32'h08);
    chk(cfg, 32'h08);
    chk(tx_char_valid, 32'h1);
    pulse(2);
    repeat (2) @(posedge aclk);
    rd(ST);
    chk(got[2], 32'h1);
    rd(32'h4006_4100);
    chk(resp, uart_status_pkg::RESP_SLVERR);
    $display("test transmit done");
    // break: confirmed start, then one tick short of the count, then the full count
    hold_low <= 1'h1;
    repeat (6) @(posedge aclk);
    pulse(0);
    repeat (15) pulse(1);
    rd(ST);
    chk(got[13:10], 32'h4);
    pulse(1);
    repeat (2) @(posedge aclk);
    rd(ST);
    chk(got[13:10], 32'hF);
    hold_low <= 1'h0;
    repeat (6) @(posedge aclk);
    rd(ST);
    chk(got[11:10], 32'h2);
    $display("test break done");
    // noise: two high samples and one low one in a bit, then a clean character end
    pulse(3);
    hold_low <= 1'h1;
    repeat (4) @(posedge aclk);
    pulse(3);
    hold_low <= 1'h0;
    repeat (4) @(posedge aclk);
    pulse(3);
    pulse(1);
    chk(vb, 32'h1);
    rx_event <= {1'h1, 9'h0AA, 2'h0};
    @(posedge aclk);
    chk(flag_events & 16'h8001, 32'h8001);
    rx_event <= '0;
    repeat (2) @(posedge aclk);
    rd(uart_status_pkg::ADDR_RX_HOLD_STAT);
    chk({got[15], got[8:0]}, 32'h2AA);
    rd(ST);
    chk(got[0], 32'h0);
    // loopback swaps the clear-to-send source while the pin stays low
    loop_cts <= 1'h1;
    wr(CF, 32'h01);
    chk(cfg, 32'h01);
    rd(ST);
    chk(got[5:4], 32'h3);
    $display("test noise and loopback done");
    final_report();
  end
endmodule : test_uart_status_flag_logic
`default_nettype wire

//--- hdl/sample_voter.sv
// three-sample majority voter for one received bit
`timescale 1ns/1ps
`default_nettype none
module sample_voter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // synchronised line and strobes
  input wire logic line_in,
  input wire logic sample_tick,
  input wire logic bit_end,
  // vote result
  output logic voted_bit,
  output logic disagree,
  output logic voted_valid
);

  logic [1:0] ones_r, ones_nxt;
  logic [1:0] seen_r, seen_nxt;
  logic voted_r, voted_nxt;
  logic dis_r, dis_nxt;
  logic valid_r, valid_nxt;

  // count high samples; vote at the end of the bit
  always_comb begin
    ones_nxt = ones_r;
    seen_nxt = seen_r;
    voted_nxt = voted_r;
    dis_nxt = dis_r;
    valid_nxt = 1'b0;
    if (sample_tick && seen_r != uart_status_pkg::SAMPLES_PER_BIT) begin
      seen_nxt = seen_r + 2'h1;
      ones_nxt = ones_r + {1'b0, line_in};
    end
    if (bit_end) begin
      voted_nxt = ones_r[1]; // two or three highs
      dis_nxt = (ones_r != 2'h0) && (ones_r != uart_status_pkg::SAMPLES_PER_BIT);
      valid_nxt = 1'b1;
      ones_nxt = 2'h0;
      seen_nxt = 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ones_r <= 2'h0;
      seen_r <= 2'h0;
      voted_r <= 1'b1;
      dis_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      ones_r <= ones_nxt;
      seen_r <= seen_nxt;
      voted_r <= voted_nxt;
      dis_r <= dis_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign voted_bit = voted_r;
  assign disagree = dis_r;
  assign voted_valid = valid_r;

endmodule : sample_voter
`default_nettype wire

//--- hdl/uart_status_flag_logic.sv
// status flag logic of the serial transceiver with its AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_status_flag_logic (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins
  input wire logic serial_input_pin,
  input wire logic cts_pin,
  // receive datapath
  input wire uart_status_pkg::rx_event_t rx_event,
  input wire logic rx_busy,
  input wire logic sample_tick,
  input wire logic bit_tick,
  input wire logic mid_sample,
  input wire logic loop_cts,
  output logic rx_voted_bit,
  output logic rx_voted_valid,
  // transmit datapath
  input wire logic tx_busy,
  input wire logic tx_take,
  output logic [8:0] tx_char,
  output logic tx_char_valid,
  // configuration and per-flag events
  output uart_status_pkg::cfg_t cfg,
  output logic [15:0] flag_events
);

  // ==========================================================================
  // pin synchronisers
  logic rxd_meta_r, rxd_r, cts_meta_r, cts_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_meta_r <= 1'b1;
      rxd_r <= 1'b1;
      cts_meta_r <= 1'b0;
      cts_r <= 1'b0;
    end else begin
      rxd_meta_r <= serial_input_pin;
      rxd_r <= rxd_meta_r;
      cts_meta_r <= cts_pin;
      cts_r <= cts_meta_r;
    end
  end

  logic voted_dis;

  sample_voter voter (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_in(rxd_r),
    .sample_tick(sample_tick),
    .bit_end(bit_tick),
    .voted_bit(rx_voted_bit),
    .disagree(voted_dis),
    .voted_valid(rx_voted_valid)
  );

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // ==========================================================================
  // AXI4-Lite slave
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [31:0] aw_addr_r, aw_addr_nxt, w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic do_write, rd_take, rd_hit;
  logic [31:0] rd_word, wmask;
  logic [31:0] status_word;
  logic [8:0] rx_data_r;

  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign rd_take = arvalid && arready;
  assign wmask = strb_mask(w_strb_r);

  // read mux; reads of the status word change nothing
  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      uart_status_pkg::ADDR_CFG: rd_word = {26'h0, cfg};
      uart_status_pkg::ADDR_STATUS: rd_word = status_word;
      uart_status_pkg::ADDR_RX_HOLD: rd_word = {23'h0, rx_data_r};
      uart_status_pkg::ADDR_RX_HOLD_STAT: rd_word = {16'h0, status_word[15:13], 4'h0, rx_data_r};
      uart_status_pkg::ADDR_TX_HOLD: rd_word = 32'h0;
      default: begin
        rd_word = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // address and data are caught in either order; the response follows both
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (aw_addr_r == uart_status_pkg::ADDR_CFG || aw_addr_r == uart_status_pkg::ADDR_STATUS ||
                   aw_addr_r == uart_status_pkg::ADDR_TX_HOLD) ? uart_status_pkg::RESP_OKAY
                                                               : uart_status_pkg::RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_word;
      rresp_nxt = rd_hit ? uart_status_pkg::RESP_OKAY : uart_status_pkg::RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 32'h0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  // ==========================================================================
  // line break detector
  uart_status_pkg::line_state_t line_r, line_nxt;
  logic [4:0] low_bits_r, low_bits_nxt;
  logic brk_rise, brk_fall;

  // counts whole bit times with the line low; any high sample ends it
  always_comb begin
    line_nxt = line_r;
    low_bits_nxt = low_bits_r;
    unique case (line_r)
      uart_status_pkg::LINE_IDLE: begin
        low_bits_nxt = 5'h0;
        if (!rxd_r) line_nxt = uart_status_pkg::LINE_LOW;
      end
      uart_status_pkg::LINE_LOW: begin
        if (rxd_r) begin
          line_nxt = uart_status_pkg::LINE_IDLE;
        end else if (bit_tick) begin
          low_bits_nxt = low_bits_r + 5'h1;
          if (low_bits_nxt == uart_status_pkg::BREAK_BITS) line_nxt = uart_status_pkg::LINE_BREAK;
        end
      end
      uart_status_pkg::LINE_BREAK: begin
        if (rxd_r) line_nxt = uart_status_pkg::LINE_IDLE;
      end
      default: line_nxt = uart_status_pkg::LINE_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_r <= uart_status_pkg::LINE_IDLE;
      low_bits_r <= 5'h0;
    end else begin
      line_r <= line_nxt;
      low_bits_r <= low_bits_nxt;
    end
  end

  assign brk_rise = (line_r != uart_status_pkg::LINE_BREAK) && (line_nxt == uart_status_pkg::LINE_BREAK);
  assign brk_fall = (line_r == uart_status_pkg::LINE_BREAK) && (line_nxt != uart_status_pkg::LINE_BREAK);

  // ==========================================================================
  // flags, holding registers and configuration
  uart_status_pkg::cfg_t cfg_r, cfg_nxt;
  logic [8:0] rx_data_nxt, tx_char_r, tx_char_nxt;
  logic avail_r, avail_nxt, rx_quiet_r, tx_quiet_r, tx_free_r, tx_free_nxt, halted_r;
  logic cts_prev_r, primed_r, rxd_prev_r, start_pend_r, start_pend_nxt;
  logic noise_acc_r, noise_acc_nxt;
  logic [15:0] sticky_r, sticky_nxt, set_ev, clr;
  logic cts_now, hold_read, hold_write, accept, noisy_bit;

  assign cts_now = cfg_r.loopback ? loop_cts : cts_r;
  assign hold_read = rd_take && (araddr == uart_status_pkg::ADDR_RX_HOLD ||
                                 araddr == uart_status_pkg::ADDR_RX_HOLD_STAT);
  assign hold_write = do_write && aw_addr_r == uart_status_pkg::ADDR_TX_HOLD && w_strb_r[0] && tx_free_r;
  assign accept = rx_event.done && (!avail_r || hold_read);
  assign noisy_bit = rx_voted_valid && voted_dis && !cfg_r.sync_mode &&
                     line_r != uart_status_pkg::LINE_BREAK;
  // only clearable bits of the status word react to a written one
  assign clr = (do_write && aw_addr_r == uart_status_pkg::ADDR_STATUS) ?
               (w_data_r[15:0] & wmask[15:0] & uart_status_pkg::W1C_MASK) : 16'h0;

  // sticky event sources; a set in the cycle of a clear wins
  always_comb begin
    set_ev = 16'h0;
    set_ev[uart_status_pkg::BIT_CTS_CHANGE] = primed_r && (cts_now != cts_prev_r);
    set_ev[uart_status_pkg::BIT_OVERFLOW] = rx_event.done && avail_r && !hold_read;
    set_ev[uart_status_pkg::BIT_BREAK_CHANGE] = brk_rise || brk_fall;
    set_ev[uart_status_pkg::BIT_START] = start_pend_r && mid_sample && !rxd_r;
    set_ev[uart_status_pkg::BIT_STOP_ERR] = (rx_event.done && rx_event.stop_bad) || brk_rise;
    set_ev[uart_status_pkg::BIT_CHECK_ERR] = rx_event.done && rx_event.parity_bad &&
                                             (cfg_r.parity_mode != 2'h0);
    set_ev[uart_status_pkg::BIT_NOISE] = accept && (noise_acc_r || noisy_bit);
    sticky_nxt = (sticky_r & ~clr) | set_ev;
    noise_acc_nxt = rx_event.done ? 1'b0 : (noise_acc_r || noisy_bit);
    avail_nxt = accept ? 1'b1 : (hold_read ? 1'b0 : avail_r);
    rx_data_nxt = accept ? rx_event.data : rx_data_r;
    tx_free_nxt = hold_write ? 1'b0 : (tx_take ? 1'b1 : tx_free_r);
    tx_char_nxt = hold_write ? w_data_r[8:0] : tx_char_r;
    start_pend_nxt = start_pend_r;
    if (rxd_prev_r && !rxd_r && !rx_busy) start_pend_nxt = 1'b1;
    else if (mid_sample) start_pend_nxt = 1'b0;
    cfg_nxt = cfg_r;
    if (do_write && aw_addr_r == uart_status_pkg::ADDR_CFG) begin
      cfg_nxt = (cfg_r & ~wmask[5:0]) | (w_data_r[5:0] & wmask[5:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= uart_status_pkg::CFG_RESET;
      sticky_r <= 16'h0;
      noise_acc_r <= 1'b0;
      avail_r <= 1'b0;
      rx_data_r <= 9'h0;
      tx_free_r <= uart_status_pkg::TX_FREE_RESET;
      tx_char_r <= 9'h0;
      rx_quiet_r <= uart_status_pkg::RX_QUIET_RESET;
      tx_quiet_r <= uart_status_pkg::TX_QUIET_RESET;
      halted_r <= 1'b0;
      cts_prev_r <= 1'b0;
      primed_r <= 1'b0;
      rxd_prev_r <= 1'b1;
      start_pend_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      sticky_r <= sticky_nxt;
      noise_acc_r <= noise_acc_nxt;
      avail_r <= avail_nxt;
      rx_data_r <= rx_data_nxt;
      tx_free_r <= tx_free_nxt;
      tx_char_r <= tx_char_nxt;
      rx_quiet_r <= !rx_busy;
      tx_quiet_r <= !tx_busy;
      halted_r <= cfg_r.transmit_halt_request && !tx_busy && !tx_take;
      cts_prev_r <= cts_now;
      primed_r <= 1'b1; // first compare after reset would see a false toggle
      rxd_prev_r <= rxd_r;
      start_pend_r <= start_pend_nxt;
    end
  end

  // live status word; reserved bits read as zero
  always_comb begin
    status_word = {16'h0, sticky_r};
    status_word[uart_status_pkg::BIT_RX_AVAIL] = avail_r;
    status_word[uart_status_pkg::BIT_RX_QUIET] = rx_quiet_r;
    status_word[uart_status_pkg::BIT_TX_FREE] = tx_free_r;
    status_word[uart_status_pkg::BIT_TX_QUIET] = tx_quiet_r;
    status_word[uart_status_pkg::BIT_CTS] = cts_now;
    status_word[uart_status_pkg::BIT_TX_HALTED] = halted_r;
    status_word[uart_status_pkg::BIT_BREAK] = (line_r == uart_status_pkg::LINE_BREAK);
  end

  // a held character is not offered while halted; one already shifting finishes
  assign tx_char_valid = !tx_free_r && !cfg_r.transmit_halt_request;
  assign tx_char = tx_char_r;
  assign cfg = cfg_r;
  assign flag_events = set_ev | {15'h0, accept} | {13'h0, tx_take, 2'h0};

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_w1c_clears: assert property (clr[uart_status_pkg::BIT_START] &&
    !set_ev[uart_status_pkg::BIT_START] |=> !sticky_r[uart_status_pkg::BIT_START])
    else $error("start flag not cleared by one");
  a_error_sticky: assert property (sticky_r[uart_status_pkg::BIT_OVERFLOW] &&
    !clr[uart_status_pkg::BIT_OVERFLOW] |=> sticky_r[uart_status_pkg::BIT_OVERFLOW])
    else $error("overrun flag lost");
  a_avail_read: assert property (hold_read && !rx_event.done |=> !avail_r)
    else $error("receive available stayed after read");
  a_rx_quiet: assert property (rx_busy ##1 rx_busy |-> !rx_quiet_r) else $error("receiver quiet while busy");
  a_txfree_cycle: assert property (hold_write |=> !tx_free_r ##0 tx_char == $past(w_data_r[8:0]))
    else $error("transmit buffer free not dropped");
  a_cts_change: assert property (primed_r && cts_now != cts_prev_r |=>
    sticky_r[uart_status_pkg::BIT_CTS_CHANGE]) else $error("clear-to-send change missed");
  a_halt_idle: assert property (halted_r |-> $past(cfg_r.transmit_halt_request) && !$past(tx_busy))
    else $error("halted flag while busy");
  a_overrun_keep: assert property (rx_event.done && avail_r && !hold_read |=>
    rx_data_r == $past(rx_data_r)) else $error("overrun character not discarded");
  a_break_count: assert property (brk_rise |-> low_bits_r == 5'hF && bit_tick)
    else $error("break asserted at wrong count");
  a_break_frame: assert property (brk_rise |=>
    sticky_r[uart_status_pkg::BIT_STOP_ERR] && sticky_r[uart_status_pkg::BIT_BREAK_CHANGE])
    else $error("break without framing error");
  a_halt_gate: assert property (cfg_r.transmit_halt_request |-> !tx_char_valid)
    else $error("character offered while halted");

endmodule : uart_status_flag_logic
`default_nettype wire

//--- hdl/uart_status_pkg.sv
// constants, field layouts and carrier types of the serial status flag block
// What this block does
// - writing one clears a clearable flag; zero leaves it; read-only flags ignore writes.
// - parity, framing, overrun flags set at detection, noise when its character is accepted; all hold until cleared.
// - receive available flag, bit 0, set while a character waits; holding read clears it.
// - receiver quiet flag, bit 1, low while receiving, else high; resets high.
// - transmit buffer free, bit 2, drops on holding write, rises when shifter takes it.
// - transmitter quiet flag, bit 3, low while shifting out; resets high.
// - bit 4 mirrors clear-to-send, pin or loopback source, regardless of flow gating.
// - bit 5 sets whenever the mirrored clear-to-send toggles; cleared by writing one.
// - transmitter halted, bit 6, only once transmitter fully idle after halt request.
// - overrun, bit 8, set when a character lands on a full buffer; it is discarded.
// - line break, bit 10, after 16 low bit times; drops when input goes high.
// - a detected line break also sets the framing error flag.
// - line break change, bit 11, sets on break start or end; software clears.
// - start flag, bit 12, set on start edge confirmed at mid-bit; software clears.
// - framing error, bit 13, set when the stop bit is missing.
// - parity error, bit 14, set on a bad parity only while parity checking enabled.
// - three samples per bit outside synchronous mode; bit 15 flags any disagreeing sample.
// - the noise flag is not updated during a received break.
// - a halt request lets the character being shifted out finish first.
package uart_status_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [31:0] ADDR_CFG = 32'h4006_4000;
  localparam logic [31:0] ADDR_STATUS = 32'h4006_4008;
  localparam logic [31:0] ADDR_RX_HOLD = 32'h4006_4014;
  localparam logic [31:0] ADDR_RX_HOLD_STAT = 32'h4006_4018;
  localparam logic [31:0] ADDR_TX_HOLD = 32'h4006_401C;

  // ==========================================================================
  // status field positions
  localparam int BIT_RX_AVAIL = 0;
  localparam int BIT_RX_QUIET = 1;
  localparam int BIT_TX_FREE = 2;
  localparam int BIT_TX_QUIET = 3;
  localparam int BIT_CTS = 4;
  localparam int BIT_CTS_CHANGE = 5;
  localparam int BIT_TX_HALTED = 6;
  localparam int BIT_OVERFLOW = 8;
  localparam int BIT_BREAK = 10;
  localparam int BIT_BREAK_CHANGE = 11;
  localparam int BIT_START = 12;
  localparam int BIT_STOP_ERR = 13;
  localparam int BIT_CHECK_ERR = 14;
  localparam int BIT_NOISE = 15;
  // bits that a written one clears
  localparam logic [15:0] W1C_MASK = 16'hF920;

  // ==========================================================================
  // reset values and counts
  localparam logic RX_QUIET_RESET = 1'h1;
  localparam logic TX_FREE_RESET = 1'h1;
  localparam logic TX_QUIET_RESET = 1'h1;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [4:0] BREAK_BITS = 5'h10;
  localparam logic [1:0] SAMPLES_PER_BIT = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic sync_mode;
    logic [1:0] parity_mode;
    logic transmit_halt_request;
    logic flow_control_gate;
    logic loopback;
  } cfg_t;

  typedef struct packed {
    logic done;
    logic [8:0] data;
    logic stop_bad;
    logic parity_bad;
  } rx_event_t;

  typedef enum logic [1:0] {
    LINE_IDLE = 2'h0,
    LINE_LOW = 2'h1,
    LINE_BREAK = 2'h2
  } line_state_t;

endpackage : uart_status_pkg
